/* File: hdl/xcb_pkg.sv */
// Purpose: Constants for the extended control and status bit bank
// Assumes: APB slave, 32-bit data, byte addresses as printed
// Notes: Bit positions and reset values for all three registers
package xcb_pkg;
  localparam logic [7:0] XCB_OFS_CTRL = 8'hC0;
  localparam logic [7:0] XCB_OFS_STAT = 8'hC8;
  localparam logic [7:0] XCB_OFS_HOST = 8'hD8;
  // Control register bits
  localparam int XCB_C_IRQ_ACK = 0;
  localparam int XCB_C_OWN = 1;
  localparam int XCB_C_VOL_UPD = 2;
  localparam int XCB_C_DLY_CLR = 3;
  localparam int XCB_C_WR_STB = 4;
  localparam int XCB_C_REG_SEL = 5;
  localparam int XCB_C_RAM_WR = 6;
  localparam int XCB_C_RD_REQ = 7;
  // Status register bits
  localparam int XCB_S_PWR_PIN = 0;
  localparam int XCB_S_VOL_BUSY = 2;
  localparam int XCB_S_SELFTEST = 3;
  localparam int XCB_S_CORE_FLAG = 4;
  localparam int XCB_S_DSP_ACK = 5;
  localparam int XCB_S_DLY_BUSY = 6;
  localparam int XCB_S_ROM_OK = 7;
  // Host register bits
  localparam int XCB_H_PWR_DN = 0;
  localparam int XCB_H_WDOG = 1;
  localparam int XCB_H_DLY_HOST = 2;
  localparam int XCB_H_DLY_WR = 3;
  localparam int XCB_H_RAM_WE = 4;
  localparam int XCB_H_HOST_MODE = 5;
  localparam int XCB_H_BASS_RDY = 6;
  localparam int XCB_H_TREB_RDY = 7;
  // Reset values: ownership, host mode and volume busy come up high
  localparam logic [7:0] XCB_CTRL_RST = 8'h02;
  localparam logic [7:0] XCB_HOST_RST = 8'h20;
  localparam logic [7:0] XCB_STAT_RST = 8'h04;
  // Self-clearing bits of the control register
  localparam logic [7:0] XCB_CTRL_PULSE = 8'hD1;
endpackage

/* File: hdl/xcb_sync.sv */
// Purpose: Two-flop synchroniser for a vector of pin levels
// Assumes: Levels only, no events narrower than two cycles
// Notes: First stage feeds nothing but the second
`timescale 1ns/10ps
module xcb_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Data
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= '0;
      s2_r <= '0;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
    end
  end
  assign dout = s2_r;
endmodule

/* File: hdl/xcb_bank.sv */
// Purpose: Extended control and status bit bank over APB
// Assumes: Status inputs are asynchronous pins; partner logic obeys its side
// Notes: Pulse bits stand high one cycle after the write edge
//
// Local design decision: register access over APB.
`timescale 1ns/10ps
module xcb_bank (
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial bus block
  output logic bus_irq_ack,
  output logic bus_ownership_bit,
  output logic bus_write_strobe,
  output logic bus_register_select,
  // Audio processor and volume
  output logic vol_update,
  output logic ram_wr_req,
  output logic rd_req,
  output logic ram_wr_en,
  output logic host_mode,
  // Delay memory and misc
  output logic dly_clear,
  output logic dly_host_access,
  output logic dly_write,
  output logic power_down,
  output logic watchdog_clr,
  output logic bass_ready,
  output logic treble_ready,
  // Status inputs
  input wire logic power_pin,
  input wire logic vol_busy_in,
  input wire logic selftest_mode_in,
  input wire logic core_flag_status,
  input wire logic dsp_ack_in,
  input wire logic dly_busy_in,
  input wire logic rom_ok_in
);
  import xcb_pkg::*;

  logic [7:0] ctrl_r, ctrl_nxt;
  logic [7:0] host_r, host_nxt;
  logic [7:0] stat_r, stat_nxt;
  logic [2:0] reg_sync;
  logic wr_ctrl, wr_host, acc;

  function automatic logic hit(input logic [31:0] a, input logic [7:0] ofs);
    hit = (a[31:8] == 24'h000000) && (a[7:0] == ofs);
  endfunction

  // Both input groups pass two flops; stat_r samples all of them once more below
  xcb_sync #(.W(3)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din({dly_busy_in, dsp_ack_in, vol_busy_in}),
    .dout(reg_sync)
  );
  logic [3:0] dir_sync;
  xcb_sync #(.W(4)) u_dsync (
    .pclk(pclk),
    .presetn(presetn),
    .din({rom_ok_in, core_flag_status, selftest_mode_in, power_pin}),
    .dout(dir_sync)
  );

  assign acc = psel && penable;
  assign wr_ctrl = acc && pwrite && hit(paddr, XCB_OFS_CTRL);
  assign wr_host = acc && pwrite && hit(paddr, XCB_OFS_HOST);
  // Zero wait states; unmapped addresses read zero and flag an error
  assign pready = 1'b1;
  assign pslverr = acc && !(hit(paddr, XCB_OFS_CTRL) || hit(paddr, XCB_OFS_STAT) || hit(paddr, XCB_OFS_HOST));

  always_comb begin
    ctrl_nxt = ctrl_r & ~XCB_CTRL_PULSE;
    if (wr_ctrl) begin
      ctrl_nxt = pwdata[7:0];
      // read request blocked in host mode
      if (host_r[XCB_H_HOST_MODE]) begin
        ctrl_nxt[XCB_C_RD_REQ] = 1'b0;
      end
      // RAM write only in host mode
      if (!host_r[XCB_H_HOST_MODE]) begin
        ctrl_nxt[XCB_C_RAM_WR] = 1'b0;
      end
    end
  end

  always_comb begin
    host_nxt = host_r;
    host_nxt[XCB_H_WDOG] = 1'b0;
    if (wr_host) begin
      host_nxt = pwdata[7:0];
    end
  end

  always_comb begin
    stat_nxt = 8'h00;
    stat_nxt[XCB_S_SELFTEST] = dir_sync[1];
    stat_nxt[XCB_S_CORE_FLAG] = dir_sync[2];
    stat_nxt[XCB_S_ROM_OK] = dir_sync[3];
    stat_nxt[XCB_S_PWR_PIN] = dir_sync[0];
    stat_nxt[XCB_S_VOL_BUSY] = reg_sync[0];
    stat_nxt[XCB_S_DSP_ACK] = reg_sync[1];
    stat_nxt[XCB_S_DLY_BUSY] = reg_sync[2];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= XCB_CTRL_RST;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_r <= XCB_HOST_RST;
    end else begin
      host_r <= host_nxt;
    end
  end

  // Volume busy comes up high until the first clock edge after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_r <= XCB_STAT_RST;
    end else begin
      stat_r <= stat_nxt;
    end
  end

  // Read data is combinational from registers so it is valid in the access cycle
  always_comb begin
    prdata = 32'h00000000;
    if (acc && !pwrite) begin
      if (hit(paddr, XCB_OFS_CTRL)) begin
        prdata[7:0] = ctrl_r;
      end else if (hit(paddr, XCB_OFS_STAT)) begin
        prdata[7:0] = stat_r;
      end else if (hit(paddr, XCB_OFS_HOST)) begin
        prdata[7:0] = host_r;
      end
    end
  end

  assign bus_irq_ack = ctrl_r[XCB_C_IRQ_ACK];
  assign bus_ownership_bit = ctrl_r[XCB_C_OWN];
  assign vol_update = ctrl_r[XCB_C_VOL_UPD];
  assign dly_clear = ctrl_r[XCB_C_DLY_CLR];
  assign bus_write_strobe = ctrl_r[XCB_C_WR_STB];
  assign bus_register_select = ctrl_r[XCB_C_REG_SEL];
  assign ram_wr_req = ctrl_r[XCB_C_RAM_WR];
  assign rd_req = ctrl_r[XCB_C_RD_REQ];
  assign power_down = host_r[XCB_H_PWR_DN];
  assign watchdog_clr = host_r[XCB_H_WDOG];
  assign dly_host_access = host_r[XCB_H_DLY_HOST];
  assign dly_write = host_r[XCB_H_DLY_WR];
  assign ram_wr_en = host_r[XCB_H_RAM_WE];
  assign host_mode = host_r[XCB_H_HOST_MODE];
  assign bass_ready = host_r[XCB_H_BASS_RDY];
  assign treble_ready = host_r[XCB_H_TREB_RDY];

  pulse_one_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(bus_write_strobe) |=> !bus_write_strobe) else $error("write strobe longer than one cycle");
  ack_one_a: assert property (@(posedge pclk) disable iff (!presetn)
    bus_irq_ack |=> !bus_irq_ack) else $error("acknowledge longer than one cycle");
  ack_cause_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(bus_irq_ack) |-> $past(wr_ctrl) && $past(pwdata[0])) else $error("acknowledge without write");
  own_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !$past(wr_ctrl) |-> $stable(bus_ownership_bit)) else $error("ownership changed without write");
  rd_blk_a: assert property (@(posedge pclk) disable iff (!presetn)
    $past(host_mode) |-> !rd_req) else $error("read request in host mode");
  ramwr_a: assert property (@(posedge pclk) disable iff (!presetn)
    ram_wr_req |-> $past(host_mode) ##1 !ram_wr_req) else $error("RAM write outside host mode");
  wdog_a: assert property (@(posedge pclk) disable iff (!presetn)
    watchdog_clr |=> !watchdog_clr) else $error("watchdog strobe stuck");
  busy_a: assert property (@(posedge pclk) disable iff (!presetn)
    $past(dly_busy_in, 3) |-> stat_r[XCB_S_DLY_BUSY]) else $error("busy status lost");
  ack_st_a: assert property (@(posedge pclk) disable iff (!presetn)
    $past(dsp_ack_in, 3) == stat_r[XCB_S_DSP_ACK]) else $error("acknowledge status wrong");
  host_wr_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_host |=> host_mode == $past(pwdata[5])) else $error("host mode not written");

  // One cycle high, then low
  sequence one_shot_s(s);
    s ##1 !s;
  endsequence

  // Write accepted to the control register
  sequence ctrl_wr_s;
    wr_ctrl;
  endsequence

  // Write accepted to the host register
  sequence host_wr_s;
    wr_host;
  endsequence

  strobe_cause_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(bus_write_strobe) |-> $past(wr_ctrl) && $past(pwdata[XCB_C_WR_STB])) else $error("strobe without write");

  strobe_shot_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(bus_write_strobe) |-> one_shot_s(bus_write_strobe)) else $error("strobe not one shot");

  rdreq_shot_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(rd_req) |-> one_shot_s(rd_req)) else $error("read request not one shot");

  rdreq_cause_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(rd_req) |-> $past(wr_ctrl) && $past(pwdata[XCB_C_RD_REQ]) && !$past(host_mode))
    else $error("read request without cause");

  ramwr_cause_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(ram_wr_req) |-> $past(wr_ctrl) && $past(pwdata[XCB_C_RAM_WR]) && $past(host_mode))
    else $error("RAM write without cause");

  ramwr_shot_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(ram_wr_req) |-> one_shot_s(ram_wr_req)) else $error("RAM write not one shot");

  wdog_cause_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(watchdog_clr) |-> $past(wr_host) && $past(pwdata[XCB_H_WDOG])) else $error("watchdog strobe without write");

  own_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_wr_s |=> bus_ownership_bit == $past(pwdata[XCB_C_OWN])) else $error("ownership not written");

  sel_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_wr_s |=> bus_register_select == $past(pwdata[XCB_C_REG_SEL])) else $error("select not written");

  sel_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !wr_ctrl |=> $stable(bus_register_select)) else $error("select changed without write");

  vol_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_wr_s |=> vol_update == $past(pwdata[XCB_C_VOL_UPD])) else $error("volume update not written");

  vol_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !wr_ctrl |=> $stable(vol_update)) else $error("volume update changed without write");

  clr_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_wr_s |=> dly_clear == $past(pwdata[XCB_C_DLY_CLR])) else $error("delay clear not written");

  clr_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !wr_ctrl |=> $stable(dly_clear)) else $error("delay clear changed without write");

  acc_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    host_wr_s |=> dly_host_access == $past(pwdata[XCB_H_DLY_HOST])) else $error("host access not written");

  acc_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !wr_host |=> $stable(dly_host_access)) else $error("host access changed without write");

  dlywr_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    host_wr_s |=> dly_write == $past(pwdata[XCB_H_DLY_WR])) else $error("delay write not written");

  dlywr_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !wr_host |=> $stable(dly_write)) else $error("delay write changed without write");

  we_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    host_wr_s |=> ram_wr_en == $past(pwdata[XCB_H_RAM_WE])) else $error("RAM enable not written");

  we_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !wr_host |=> $stable(ram_wr_en)) else $error("RAM enable changed without write");

  host_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !wr_host |=> $stable(host_mode)) else $error("host mode changed without write");

  tone_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    host_wr_s |=> {treble_ready, bass_ready} == $past(pwdata[7:6])) else $error("tone ready not written");

  tone_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !wr_host |=> $stable({treble_ready, bass_ready})) else $error("tone ready changed without write");

  pwr_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !wr_host |=> $stable(power_down)) else $error("power-down changed without write");

  selftest_st_a: assert property (@(posedge pclk) disable iff (!presetn)
    $past(selftest_mode_in, 3) == stat_r[XCB_S_SELFTEST]) else $error("self-test status wrong");

  flag_st_a: assert property (@(posedge pclk) disable iff (!presetn)
    $past(core_flag_status, 3) == stat_r[XCB_S_CORE_FLAG]) else $error("core flag status wrong");

  rom_st_a: assert property (@(posedge pclk) disable iff (!presetn)
    $past(rom_ok_in, 3) == stat_r[XCB_S_ROM_OK]) else $error("ROM pass status wrong");
endmodule

/* File: tb/xcb_far.sv */
// Purpose: Far-side model of volume, processor and delay memory
// Assumes: Each request answered by a level held HOLD cycles
// Notes: HOLD is a model choice, short to keep runs brief
`timescale 1ns/10ps
module xcb_far #(
  parameter int HOLD = 12
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Requests
  input wire logic vol_update,
  input wire logic rd_req,
  input wire logic dly_clear,
  // Status back
  output logic vol_busy_in,
  output logic dsp_ack_in,
  output logic dly_busy_in
);
  int cv, ca, cd;
  logic pv, pd;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {cv, ca, cd, pv, pd} <= '0;
    end else begin
      pv <= vol_update;
      pd <= dly_clear;
      cv <= (vol_update && !pv) ? HOLD : (cv > 0 ? cv - 1 : 0);
      ca <= rd_req ? HOLD : (ca > 0 ? ca - 1 : 0);
      cd <= (dly_clear && !pd) ? HOLD : (cd > 0 ? cd - 1 : 0);
    end
  end
  assign vol_busy_in = cv != 0;
  assign dsp_ack_in = ca != 0;
  assign dly_busy_in = cd != 0;
endmodule

/* File: tb/mcu_extended_control_status_bits_tb.sv */
// Purpose: Self-checking bench for the control and status bit bank
// Assumes: Zero-wait APB slave, status seen 3 edges after a pin change
// Notes: Volume updates are held back while busy, as software must
`timescale 1ns/10ps
`define chk(n, e, s) begin n_checks++; if ((s) !== (e)) begin miscompares++; \
  $display("unexpected %s exp %0h got %0h", n, e, s); end end
module mcu_extended_control_status_bits_tb;
  import xcb_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err, hm = 1;
  logic [31:0] paddr = 0, pwdata = 0, prdata, rd;
  logic pready, pslverr, pp = 0, st = 0, cf = 0, ro = 0, vb, da, db;
  logic iak, own, wst, rsl, vu, rwq, rrq, rwe, hmd, dcl, dh, dw, pdn, wc, bs, tr;
  logic [7:0] ca [6] = '{8'hD8, 8'hC0, 8'hC0, 8'hC0, 8'hD8, 8'hC0};
  logic [7:0] cd [6] = '{8'hFF, 8'h01, 8'h02, 8'hF1, 8'h00, 8'hD1};
  logic [7:0] a, d;
  int miscompares = 0, n_checks = 0, cyc = 0;
  xcb_bank uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bus_irq_ack(iak), .bus_ownership_bit(own), .bus_write_strobe(wst), .bus_register_select(rsl),
    .vol_update(vu), .ram_wr_req(rwq), .rd_req(rrq), .ram_wr_en(rwe), .host_mode(hmd),
    .dly_clear(dcl), .dly_host_access(dh), .dly_write(dw), .power_down(pdn), .watchdog_clr(wc),
    .bass_ready(bs), .treble_ready(tr), .power_pin(pp), .vol_busy_in(vb), .selftest_mode_in(st),
    .core_flag_status(cf), .dsp_ack_in(da), .dly_busy_in(db), .rom_ok_in(ro));
  xcb_far far (.pclk(pclk), .presetn(presetn), .vol_update(vu), .rd_req(rrq), .dly_clear(dcl),
    .vol_busy_in(vb), .dsp_ack_in(da), .dly_busy_in(db));
  initial begin
    forever #2 pclk = ~pclk;
  end
  task automatic conclude();
    if (miscompares == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      conclude();
    end
  end
  task automatic apb(input logic w, input logic [7:0] ad, input logic [7:0] wd);
    // Idle edge first, so back-to-back calls never reassign psel in one step
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= {24'h0, ad};
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'h1;
    @(negedge pclk);
    while (pready !== 1'h1) begin
      @(posedge pclk);
      @(negedge pclk);
    end
    rd = prdata;
    err = pslverr;
    @(posedge pclk);
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  function automatic logic [4:0] pexp(logic [7:0] ad, logic [7:0] v, logic h);
    if (ad == XCB_OFS_CTRL) return {1'h0, v[7] & ~h, v[6] & h, v[4], v[0]};
    return {v[1], 4'h0};
  endfunction
  task automatic wr(input logic [7:0] ad, input logic [7:0] v);
    apb(1'h1, ad, v);
    @(negedge pclk);
    `chk("pulses", pexp(ad, v, hm), {wc, rrq, rwq, wst, iak})
    @(negedge pclk);
    `chk("pulses off", 5'h00, {wc, rrq, rwq, wst, iak})
    if (ad == XCB_OFS_CTRL) `chk("ctrl levels", {v[5], v[3:1]}, {rsl, dcl, vu, own})
    else `chk("host levels", {v[7:2], v[0]}, {tr, bs, hmd, rwe, dw, dh, pdn})
    if (ad == XCB_OFS_HOST) hm = v[5];
    apb(1'h0, ad, 8'h00);
    `chk("readback", {24'h0, v & (ad == XCB_OFS_CTRL ? ~XCB_CTRL_PULSE : 8'hFD)}, rd)
  endtask
  task automatic stat(input logic [2:0] busy);
    apb(1'h0, XCB_OFS_STAT, 8'h00);
    `chk("status", {24'h0, ro, busy[2:1], cf, st, busy[0], 1'h0, pp}, rd)
  endtask
  initial begin
    void'($urandom(32'hd7e82a2e));
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    `chk("reset outs", 3'h6, {own, hmd, pdn})
    apb(1'h0, XCB_OFS_CTRL, 8'h00);
    `chk("ctrl reset", {24'h0, XCB_CTRL_RST}, rd)
    apb(1'h0, XCB_OFS_HOST, 8'h00);
    `chk("host reset", {24'h0, XCB_HOST_RST}, rd)
    apb(1'h0, 8'hC4, 8'h00);
    `chk("unmapped", 33'h100000000, {err, rd})
    for (int i = 0; i < 22; i++) begin
      a = i < 6 ? ca[i] : ($urandom % 2 ? XCB_OFS_CTRL : XCB_OFS_HOST);
      d = i < 6 ? cd[i] : 8'($urandom);
      if (a == XCB_OFS_CTRL && vb) d[2] = vu;
      wr(a, d);
    end
    {pp, st, cf, ro} <= 4'($urandom);
    wr(XCB_OFS_HOST, 8'h00);
    while (vb) @(posedge pclk);
    wr(XCB_OFS_CTRL, 8'h00);
    wr(XCB_OFS_CTRL, 8'h8C);
    repeat (5) @(posedge pclk);
    stat(3'h7);
    apb(1'h1, XCB_OFS_STAT, 8'hFF);
    repeat (20) @(posedge pclk);
    stat(3'h0);
    conclude();
  end
endmodule
